/* File: include/sd_link_consts.svh */
// Contract
// - controller clocks modulator between 5 and 22 MHz
// - modulator loop advances once per clock cycle
// - feedback level follows comparator on next clock
// - zero input gives ones half the time
// - positive linear limit gives 78.1 percent ones
// - negative linear limit gives 21.9 percent ones
// - clip levels force all ones or zeros
// - one data bit per modulator clock cycle
// - bit changes on falling edge, sampled rising
// - receiver decimates stream with low-pass filter
// - decimation filter is third-order sinc
// - ratio selectable 16 to 256, default 256
// - one word per ratio modulator clock cycles
// - first three words after step are unsettled; settled_o already rises with the third word after a clear
// - optional fast path: sinc2 times one plus delay
// - strobe registers integrator, three differences make word
// - filter registers 24-bit wrapping, async active-low clear
// - clock period 45.5 to 200 ns, phases 20 ns
`ifndef SD_LINK_CONSTS_SVH
`define SD_LINK_CONSTS_SVH

// system clock
`define REF_CLK_PERIOD_PS 4000
// modulator clock limits
`define MOD_CLK_PERIOD_MIN_PS 45500
`define MOD_CLK_PERIOD_MAX_PS 200000
`define MOD_CLK_PHASE_MIN_PS 20000
// half period in system cycles, least time rounded up
`define MOD_CLK_HALF_CYCLES \
	((`MOD_CLK_PERIOD_MIN_PS + 2 * `REF_CLK_PERIOD_PS - 1) / \
	(2 * `REF_CLK_PERIOD_PS))

// input levels in millivolts
`define LINEAR_LIMIT_MV 250
`define CLIP_LIMIT_MV 320
// loop levels, full density is +/- FULL_LEVEL
`define FULL_LEVEL 1024
// 78.1 percent ones: (0.781 - 0.5) * 2 * 1024
`define LINEAR_LEVEL 576
`define MV_ZERO 11'h000

// decimation
`define OSR_MIN 16
`define OSR_MAX 256
`define OSR_DEFAULT 9'h100
`define SETTLE_WORDS 3
`define WORD_ZERO 24'h000000

`endif

/* File: include/sd_link_pkg.sv */
package sd_link_pkg;

	// filter word, 24-bit wrapping unsigned
	typedef logic [23:0] word_t;
	// differential input in millivolts, signed
	typedef logic signed [10:0] mv_t;
	// loop level and integrators
	typedef logic signed [19:0] level_t;
	typedef logic signed [23:0] integ_t;
	// oversampling ratio
	typedef logic [8:0] osr_t;

	typedef enum logic [1:0] {
		SETTLE_0 = 2'b00,
		SETTLE_1 = 2'b01,
		SETTLE_2 = 2'b10,
		SETTLED = 2'b11
	} settle_state_t;

endpackage

/* File: include/sd_link_if.sv */
`timescale 1ns/10ps
interface sd_link_if;
	logic modulator_clock;
	logic bitstream;

	// the filter end makes the clock, the modulator drives the bits
	modport modulator (
		input modulator_clock,
		output bitstream
	);
	modport filter (
		output modulator_clock,
		input bitstream
	);
endinterface

/* File: hdl/sd_modulator.sv */
`timescale 1ns/10ps
`include "sd_link_consts.svh"
module sd_modulator
	import sd_link_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire mv_t sample_mv_i,
	input wire logic sample_valid_i,
	output logic sample_ready_o,
	sd_link_if.modulator link
);

	// millivolts to loop level, piecewise through the linear knee
	function automatic level_t mv_to_level(input mv_t v);
		logic [19:0] a;
		logic [19:0] m;
		begin
			a = v[10] ? 20'(-v) : 20'(v);
			if (a >= 20'(`CLIP_LIMIT_MV)) begin
				m = 20'(`FULL_LEVEL);
			end else if (a > 20'(`LINEAR_LIMIT_MV)) begin
				m = 20'(`LINEAR_LEVEL) + 20'((a - 20'(`LINEAR_LIMIT_MV))
					* 20'(`FULL_LEVEL - `LINEAR_LEVEL)
					/ 20'(`CLIP_LIMIT_MV - `LINEAR_LIMIT_MV));
			end else begin
				m = 20'(a * 20'(`LINEAR_LEVEL) / 20'(`LINEAR_LIMIT_MV));
			end
			mv_to_level = v[10] ? -level_t'(m) : level_t'(m);
		end
	endfunction

	logic clk_s1_reg, clk_s2_reg, clk_s3_reg;
	logic [1:0] count_reg;
	logic wr_ptr_reg, rd_ptr_reg;
	mv_t mem_reg [0:1];
	mv_t cur_mv_reg;
	integ_t int1_reg, int2_reg;
	logic bit_reg;

	// link clock is a pin: two flops, then an edge flop
	always_ff @(posedge ref_clk_i) begin
		clk_s1_reg <= link.modulator_clock;
		clk_s2_reg <= clk_s1_reg;
		clk_s3_reg <= clk_s2_reg;
	end

	wire fall_en = clk_s3_reg & ~clk_s2_reg;
	wire push = sample_valid_i & sample_ready_o;
	wire pop = fall_en & (count_reg != 2'h0);
	assign sample_ready_o = (count_reg != 2'h2);

	// two-entry buffer, drained one word per modulator cycle
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			count_reg <= 2'h0;
			wr_ptr_reg <= 1'b0;
			rd_ptr_reg <= 1'b0;
		end else begin
			if (push) begin
				wr_ptr_reg <= ~wr_ptr_reg;
			end
			if (pop) begin
				rd_ptr_reg <= ~rd_ptr_reg;
			end
			count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (push) begin
			mem_reg[wr_ptr_reg] <= sample_mv_i;
		end
	end

	// input held when the buffer runs dry
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			cur_mv_reg <= `MV_ZERO;
		end else if (pop) begin
			cur_mv_reg <= mem_reg[rd_ptr_reg];
		end
	end

	// loop decode
	wire level_t level = mv_to_level(cur_mv_reg);
	wire clip_pos = ~cur_mv_reg[10] &
		(cur_mv_reg >= mv_t'(`CLIP_LIMIT_MV));
	wire clip_neg = cur_mv_reg[10] &
		(cur_mv_reg <= -mv_t'(`CLIP_LIMIT_MV));
	// dac takes the previous comparator decision
	wire integ_t fb = bit_reg ? integ_t'(`FULL_LEVEL) :
		-integ_t'(`FULL_LEVEL);
	wire integ_t int1_next = int1_reg + integ_t'(level) - fb;
	wire integ_t int2_next = int2_reg + int1_next - fb;

	// one loop step per falling edge; zero input settles to 50 percent
	// integrators cleared to zero while clipped so the loop does not wind up
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			int1_reg <= '0;
			int2_reg <= '0;
			bit_reg <= 1'b0;
		end else if (fall_en) begin
			if (clip_pos | clip_neg) begin
				int1_reg <= '0;
				int2_reg <= '0;
				bit_reg <= clip_pos;
			end else begin
				int1_reg <= int1_next;
				int2_reg <= int2_next;
				bit_reg <= ~int2_next[23];
			end
		end
	end

	assign link.bitstream = bit_reg;

endmodule

/* File: hdl/sd_decimator.sv */
`timescale 1ns/10ps
`include "sd_link_consts.svh"
module sd_decimator
	import sd_link_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic filter_reset_n_i,
	input wire osr_t osr_i,
	output word_t filtered_word_o,
	output word_t fast_word_o,
	output logic word_valid_o,
	output logic settled_o,
	output logic decimation_strobe_o,
	sd_link_if.filter link
);

	localparam logic [2:0] HALF_CYCLES = 3'(`MOD_CLK_HALF_CYCLES);

	// clamp a requested ratio to the supported span
	function automatic osr_t clamp_osr(input osr_t r);
		begin
			if (r < osr_t'(`OSR_MIN)) begin
				clamp_osr = osr_t'(`OSR_MIN);
			end else if (r > osr_t'(`OSR_MAX)) begin
				clamp_osr = osr_t'(`OSR_MAX);
			end else begin
				clamp_osr = r;
			end
		end
	endfunction

	logic [2:0] div_cnt_reg;
	logic mclk_reg;
	logic bs_s1_reg, bs_s2_reg;
	osr_t osr_reg;
	osr_t dec_cnt_reg;
	logic decimation_strobe_reg;
	logic strobe_d_reg;
	word_t ones_accumulator_reg;
	word_t cn1_reg, cn2_reg;
	word_t dn0_reg, dn1_reg, dn3_reg, dn5_reg;
	word_t fd0_reg, fd1_reg, fd2_reg;
	word_t fh1_reg, fh2_reg;
	word_t filtered_word_reg, fast_word_reg;
	logic word_valid_reg;
	settle_state_t settle_reg, settle_next;

	// clock divider: equal phases, period not below the minimum
	// a 250 MHz base cannot hit 45.5 ns exactly, so 48 ns is used
	wire div_wrap = (div_cnt_reg == HALF_CYCLES - 3'h1);
	wire rise_en = div_wrap & ~mclk_reg;

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			div_cnt_reg <= 3'h0;
			mclk_reg <= 1'b0;
		end else if (div_wrap) begin
			div_cnt_reg <= 3'h0;
			mclk_reg <= ~mclk_reg;
		end else begin
			div_cnt_reg <= div_cnt_reg + 3'h1;
		end
	end

	assign link.modulator_clock = mclk_reg;

	// returning bits cross from the pin through two flops
	always_ff @(posedge ref_clk_i) begin
		bs_s1_reg <= link.bitstream;
		bs_s2_reg <= bs_s1_reg;
	end

	// three integrators step on each rising modulator edge
	// the bit changed half a period earlier, so it is stable here
	always_ff @(posedge ref_clk_i or negedge filter_reset_n_i) begin
		if (!filter_reset_n_i) begin
			ones_accumulator_reg <= `WORD_ZERO;
			cn1_reg <= `WORD_ZERO;
			cn2_reg <= `WORD_ZERO;
		end else if (rst_i) begin
			ones_accumulator_reg <= `WORD_ZERO;
			cn1_reg <= `WORD_ZERO;
			cn2_reg <= `WORD_ZERO;
		end else if (rise_en) begin
			ones_accumulator_reg <= ones_accumulator_reg +
				{23'h000000, bs_s2_reg};
			cn1_reg <= cn1_reg + ones_accumulator_reg;
			cn2_reg <= cn2_reg + cn1_reg;
		end
	end

	// decimation counter in modulator cycles; ratio taken at a boundary
	// so a change never produces a short or long word
	wire dec_wrap = (dec_cnt_reg == osr_reg - osr_t'(1));

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			osr_reg <= `OSR_DEFAULT;
			dec_cnt_reg <= '0;
			decimation_strobe_reg <= 1'b0;
		end else begin
			decimation_strobe_reg <= rise_en & dec_wrap;
			if (rise_en) begin
				if (dec_wrap) begin
					dec_cnt_reg <= '0;
					osr_reg <= clamp_osr(osr_i);
				end else begin
					dec_cnt_reg <= dec_cnt_reg + osr_t'(1);
				end
			end
		end
	end

	// sinc3 comb: three successive differences
	wire word_t cn3 = dn0_reg - dn1_reg;
	wire word_t cn4 = cn3 - dn3_reg;
	wire word_t comb_word = cn4 - dn5_reg;

	always_ff @(posedge ref_clk_i or negedge filter_reset_n_i) begin
		if (!filter_reset_n_i) begin
			dn0_reg <= `WORD_ZERO;
			dn1_reg <= `WORD_ZERO;
			dn3_reg <= `WORD_ZERO;
			dn5_reg <= `WORD_ZERO;
		end else if (rst_i) begin
			dn0_reg <= `WORD_ZERO;
			dn1_reg <= `WORD_ZERO;
			dn3_reg <= `WORD_ZERO;
			dn5_reg <= `WORD_ZERO;
		end else if (decimation_strobe_reg) begin
			dn0_reg <= cn2_reg;
			dn1_reg <= dn0_reg;
			dn3_reg <= cn3;
			dn5_reg <= cn4;
		end
	end

	// fast path: sinc2 off the second integrator, then 1 + z^-2
	// at the word rate; settles a word after the sinc3 path, for trip detection
	wire word_t fe1 = fd0_reg - fd1_reg;
	wire word_t fe2 = fe1 - fd2_reg;
	wire word_t fast_sum = fe2 + fh2_reg;

	always_ff @(posedge ref_clk_i or negedge filter_reset_n_i) begin
		if (!filter_reset_n_i) begin
			fd0_reg <= `WORD_ZERO;
			fd1_reg <= `WORD_ZERO;
			fd2_reg <= `WORD_ZERO;
			fh1_reg <= `WORD_ZERO;
			fh2_reg <= `WORD_ZERO;
		end else if (rst_i) begin
			fd0_reg <= `WORD_ZERO;
			fd1_reg <= `WORD_ZERO;
			fd2_reg <= `WORD_ZERO;
			fh1_reg <= `WORD_ZERO;
			fh2_reg <= `WORD_ZERO;
		end else if (decimation_strobe_reg) begin
			fd0_reg <= cn1_reg;
			fd1_reg <= fd0_reg;
			fd2_reg <= fe1;
			fh1_reg <= fe2;
			fh2_reg <= fh1_reg;
		end
	end

	// output words registered one cycle after the comb update
	always_ff @(posedge ref_clk_i or negedge filter_reset_n_i) begin
		if (!filter_reset_n_i) begin
			strobe_d_reg <= 1'b0;
			filtered_word_reg <= `WORD_ZERO;
			fast_word_reg <= `WORD_ZERO;
			word_valid_reg <= 1'b0;
		end else if (rst_i) begin
			strobe_d_reg <= 1'b0;
			filtered_word_reg <= `WORD_ZERO;
			fast_word_reg <= `WORD_ZERO;
			word_valid_reg <= 1'b0;
		end else begin
			strobe_d_reg <= decimation_strobe_reg;
			word_valid_reg <= strobe_d_reg;
			if (strobe_d_reg) begin
				filtered_word_reg <= comb_word;
				fast_word_reg <= fast_sum;
			end
		end
	end

	// settling: a word counts as good from the third word after a clear on
	// a ratio change restarts the count, the old history is stale
	wire osr_change = rise_en & dec_wrap & (clamp_osr(osr_i) != osr_reg);

	always_comb begin
		settle_next = settle_reg;
		if (osr_change) begin
			settle_next = SETTLE_0;
		end else if (strobe_d_reg) begin
			unique case (settle_reg)
				SETTLE_0: begin
					settle_next = SETTLE_1;
				end
				SETTLE_1: begin
					settle_next = SETTLE_2;
				end
				SETTLE_2: begin
					settle_next = SETTLED;
				end
				SETTLED: begin
					settle_next = SETTLED;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_i or negedge filter_reset_n_i) begin
		if (!filter_reset_n_i) begin
			settle_reg <= SETTLE_0;
		end else if (rst_i) begin
			settle_reg <= SETTLE_0;
		end else begin
			settle_reg <= settle_next;
		end
	end

	assign filtered_word_o = filtered_word_reg;
	assign fast_word_o = fast_word_reg;
	assign word_valid_o = word_valid_reg;
	assign settled_o = (settle_reg == SETTLED);
	assign decimation_strobe_o = decimation_strobe_reg;

endmodule

/* File: verif/sd_link_sva.sv */
`timescale 1ns/10ps
module sd_link_sva (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic filter_reset_n_i,
	input wire logic modulator_clock,
	input wire logic bitstream,
	input wire logic decimation_strobe_o,
	input wire logic word_valid_o
);
	int unsigned gap_reg;
	logic seen_reg;

	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (rst_i);

	// cycles since last strobe; a filter clear may restart the count
	always_ff @(posedge ref_clk_i) begin
		if (rst_i || !filter_reset_n_i) begin
			gap_reg <= 0;
			seen_reg <= 1'b0;
		end else if (decimation_strobe_o) begin
			gap_reg <= 1;
			seen_reg <= 1'b1;
		end else begin
			gap_reg <= gap_reg + 1;
		end
	end

	sequence s_high_phase;
		modulator_clock [*5] ##1 !modulator_clock;
	endsequence
	sequence s_low_phase;
		!modulator_clock [*5] ##1 modulator_clock;
	endsequence
	sequence s_word_out;
		##2 word_valid_o;
	endsequence

	a_clk_high_width: assert property (
		$rose(modulator_clock) |=> s_high_phase)
		else $error("link clock high phase wrong");
	a_clk_low_width: assert property (
		$fell(modulator_clock) |=> s_low_phase)
		else $error("link clock low phase wrong");
	a_bit_on_low: assert property (
		$changed(bitstream) |-> !modulator_clock)
		else $error("bit changed while clock high");
	a_bit_once_period: assert property (
		$changed(bitstream) |=> $stable(bitstream) [*8])
		else $error("bit changed twice in a period");
	a_strobe_clk_high: assert property (
		decimation_strobe_o |-> modulator_clock)
		else $error("strobe away from clock rise");
	a_strobe_single: assert property (
		decimation_strobe_o |=> !decimation_strobe_o [*8])
		else $error("strobe too long");
	a_strobe_word_out: assert property (
		decimation_strobe_o && filter_reset_n_i |-> s_word_out)
		else $error("no word two cycles after strobe");
	a_word_cause: assert property (
		$rose(word_valid_o) |-> $past(decimation_strobe_o, 2))
		else $error("word without strobe");
	a_strobe_gap: assert property (
		decimation_strobe_o && seen_reg |-> gap_reg % 12 == 0 &&
		gap_reg >= 192 && gap_reg <= 3072)
		else $error("strobe spacing wrong");
endmodule

/* File: verif/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
	import sd_link_pkg::*;
	logic ref_clk_i;
	logic rst_i;
	logic filter_reset_n_i;
	mv_t sample_mv_i;
	logic sample_valid_i;
	logic sample_ready_o;
	osr_t osr_i;
	word_t filtered_word_o;
	word_t fast_word_o;
	logic word_valid_o;
	logic settled_o;
	logic decimation_strobe_o;
	int err_total;
	int n_tests;

	sd_link_if link_if();
	sd_modulator sd_modulator_i (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.sample_mv_i(sample_mv_i),
		.sample_valid_i(sample_valid_i),
		.sample_ready_o(sample_ready_o),
		.link(link_if)
	);
	sd_decimator sd_decimator_i (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.filter_reset_n_i(filter_reset_n_i),
		.osr_i(osr_i),
		.filtered_word_o(filtered_word_o),
		.fast_word_o(fast_word_o),
		.word_valid_o(word_valid_o),
		.settled_o(settled_o),
		.decimation_strobe_o(decimation_strobe_o),
		.link(link_if)
	);
	sd_link_sva sd_link_sva_i (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.filter_reset_n_i(filter_reset_n_i),
		.modulator_clock(link_if.modulator_clock),
		.bitstream(link_if.bitstream),
		.decimation_strobe_o(decimation_strobe_o),
		.word_valid_o(word_valid_o)
	);

	initial begin
		ref_clk_i = 1'b0;
		forever #2 ref_clk_i = ~ref_clk_i;
	end

	task automatic complete_run();
		if (err_total == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic check(input logic ok, input string msg);
		n_tests++;
		if (ok !== 1'b1) begin
			err_total++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask

	// ends on the falling edge where the word pulse is seen
	task automatic wait_valid();
		int n;
		n = 0;
		@(negedge ref_clk_i);
		while (word_valid_o !== 1'b1 && n < 4000) begin
			@(negedge ref_clk_i);
			n++;
		end
		check(n < 4000, "no word");
	endtask

	// ready is settled on the falling edge, so it decides the next take
	task automatic send(input mv_t mv);
		int n;
		sample_mv_i = mv;
		sample_valid_i = 1'b1;
		n = 0;
		while (sample_ready_o !== 1'b1 && n < 100) begin
			@(negedge ref_clk_i);
			n++;
		end
		@(negedge ref_clk_i);
		sample_valid_i = 1'b0;
	endtask

	task automatic t_reset();
		check(filtered_word_o === 24'h000000, "word after reset");
		check(fast_word_o === 24'h000000, "fast after reset");
		check(word_valid_o === 1'b0 && settled_o === 1'b0,
			"flags");
		check(sample_ready_o === 1'b1, "ready after reset");
		check(link_if.modulator_clock === 1'b0, "clock idle");
	endtask

	task automatic t_clock();
		int hi;
		int lo;
		hi = 0;
		lo = 0;
		while (link_if.modulator_clock !== 1'b1 && lo < 40) begin
			@(negedge ref_clk_i);
			lo++;
		end
		lo = 0;
		while (link_if.modulator_clock === 1'b1 && hi < 40) begin
			@(negedge ref_clk_i);
			hi++;
		end
		while (link_if.modulator_clock === 1'b0 && lo < 40) begin
			@(negedge ref_clk_i);
			lo++;
		end
		check(hi == 6 && lo == 6, "link clock phases");
	endtask

	// clear in mid-run, then watch settling restart
	// the clear waits a cycle so the word pulse is seen whole
	task automatic t_settle();
		wait_valid();
		@(negedge ref_clk_i);
		filter_reset_n_i = 1'b0;
		#1;
		check(filtered_word_o === 24'h000000, "async clear");
		check(settled_o === 1'b0, "settle cleared");
		@(negedge ref_clk_i);
		filter_reset_n_i = 1'b1;
		wait_valid();
		wait_valid();
		check(settled_o === 1'b0, "settled too early");
		wait_valid();
		@(negedge ref_clk_i);
		check(settled_o === 1'b1, "not settled");
	endtask

	// bits are taken at link clock rises, where they stand still
	task automatic density(input mv_t mv, input int ones, input word_t w,
		input word_t f, input word_t tol, input int btol);
		int k;
		int n;
		int t;
		logic p;
		send(mv);
		repeat (6) wait_valid();
		check(filtered_word_o + tol >= w &&
			filtered_word_o <= w + tol, "sinc3");
		check(fast_word_o + (tol >> 2) >= f &&
			fast_word_o <= f + (tol >> 2), "fast");
		k = 0;
		n = 0;
		t = 0;
		p = 1'b1;
		while (k < 64 && t < 2000) begin
			@(negedge ref_clk_i);
			t++;
			if (link_if.modulator_clock === 1'b1 && p === 1'b0) begin
				k++;
				n += link_if.bitstream;
			end
			p = link_if.modulator_clock;
		end
		check(k == 64 && n >= ones - btol && n <= ones + btol,
			"bit density");
	endtask

	// two words held block a third until the loop takes one
	task automatic t_buffer();
		int n;
		n = 0;
		@(posedge link_if.modulator_clock);
		@(negedge ref_clk_i);
		sample_mv_i = 11'h000;
		sample_valid_i = 1'b1;
		repeat (2) @(negedge ref_clk_i);
		check(sample_ready_o === 1'b0, "buffer full");
		while (sample_ready_o !== 1'b1 && n < 20) begin
			@(negedge ref_clk_i);
			n++;
		end
		check(n < 20, "buffer not drained");
		@(negedge ref_clk_i);
		sample_valid_i = 1'b0;
	endtask

	task automatic ratio(input osr_t r, input int cyc);
		int n;
		osr_i = r;
		wait_valid();
		wait_valid();
		n = 0;
		do begin
			@(negedge ref_clk_i);
			n++;
		end while (word_valid_o !== 1'b1 && n < 4000);
		check(n == cyc, "word spacing");
	endtask

	initial begin
		err_total = 0;
		n_tests = 0;
		rst_i = 1'b1;
		filter_reset_n_i = 1'b1;
		sample_mv_i = 11'h000;
		sample_valid_i = 1'b0;
		osr_i = 9'h010;
		repeat (20) @(negedge ref_clk_i);
		rst_i = 1'b0;
		@(negedge ref_clk_i);
		t_reset();
		t_clock();
		t_settle();
		density(11'h000, 32, 24'h000800, 24'h000100, 24'h000040, 3);
		density(11'h0FA, 50, 24'h000C80, 24'h000190, 24'h000040, 3);
		density(11'h706, 14, 24'h000380, 24'h000070, 24'h000040, 3);
		density(11'h140, 64, 24'h001000, 24'h000200, 24'h000000, 0);
		density(11'h6C0, 0, 24'h000000, 24'h000000, 24'h000000, 0);
		density(11'h190, 64, 24'h001000, 24'h000200, 24'h000000, 0);
		density(11'h670, 0, 24'h000000, 24'h000000, 24'h000000, 0);
		t_buffer();
		ratio(9'h010, 192);
		ratio(9'h008, 192);
		ratio(9'h12C, 3072);
		ratio(9'h040, 768);
		complete_run();
	end

	// longest expected run is near 30000 cycles
	initial begin
		repeat (80000) @(posedge ref_clk_i);
		err_total++;
		complete_run();
	end
endmodule
